/* File: shared/bsw_pkg.sv */
// constants and carrier types for the burst sram address and write control
package bsw_pkg;

  localparam int ADDR_W = 17;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int LANE_W = 8;
  localparam int BURST_W = 2;
  localparam int FIFO_DEPTH = 32;

  localparam int ADDR_LSB_POS = 0;
  localparam int ADDR_UPPER_POS = 2;

  localparam logic [ADDR_W-1:0] ADDR_RESET = 17'h00000;
  localparam logic [BURST_W-1:0] BURST_RESET = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP_ONE = 2'h1;
  localparam logic [LANES-1:0] LANES_NONE = 4'h0;
  localparam logic [LANES-1:0] LANES_ALL = 4'hf;
  localparam logic [DATA_W-1:0] DATA_RESET = 32'h00000000;
  localparam logic [LANES-1:0] PARITY_RESET = 4'h0;

  // one write, as handed to the array side
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] lanes;
    logic [LANES-1:0] parity;
    logic [DATA_W-1:0] data;
  } bsw_wr_cmd_type;

  localparam int WR_CMD_W = $bits(bsw_wr_cmd_type);

  // chip enable trio as sampled at the edge
  typedef struct packed {
    logic sel_a_n;
    logic sel_b;
    logic sel_c_n;
  } bsw_chip_sel_type;

  typedef enum logic [1:0] {
    BSW_IDLE,
    BSW_ACTIVE,
    BSW_STANDBY
  } bsw_state_type;

endpackage

/* File: hdl/bsw_fifo.sv */
// parameterised flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ns
module bsw_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic i_clk_sys, // system clock
  input wire logic i_reset, // synchronous reset, active high
  input wire logic i_in_valid, // write side offers a word
  output logic o_in_ready, // room for a word
  input wire logic [WIDTH-1:0] i_in_data, // word to store
  output logic o_out_valid, // a word is available
  input wire logic i_out_ready, // drain side takes the word
  output logic [WIDTH-1:0] o_out_data, // oldest word
  output logic [$clog2(DEPTH):0] o_level // words held
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] DEPTH_C = (PTR_W+1)'(DEPTH);
  localparam logic [PTR_W:0] ONE_C = (PTR_W+1)'(1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg, wr_ptr_next;
  logic [PTR_W-1:0] rd_ptr_reg, rd_ptr_next;
  logic [PTR_W:0] count_reg, count_next;
  logic in_ready_reg, in_ready_next;
  logic out_valid_reg, out_valid_next;
  logic push, pop;

  assign push = i_in_valid & in_ready_reg;
  assign pop = i_out_ready & out_valid_reg;

  always_comb begin
    wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + ONE_C;
    end else if (pop && !push) begin
      count_next = count_reg - ONE_C;
    end
    // flags registered so that full and empty are honest at the ports
    in_ready_next = (count_next != DEPTH_C);
    out_valid_next = (count_next != '0);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      in_ready_reg <= 1'b0;
      out_valid_reg <= 1'b0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
      in_ready_reg <= in_ready_next;
      out_valid_reg <= out_valid_next;
    end
  end

  genvar e;
  generate
    for (e = 0; e < DEPTH; e++) begin : g_entry
      always_ff @(posedge i_clk_sys) begin
        if (push && wr_ptr_reg == PTR_W'(e)) begin
          mem_reg[e] <= i_in_data;
        end
      end
    end
  endgenerate

  assign o_in_ready = in_ready_reg;
  assign o_out_valid = out_valid_reg;
  assign o_out_data = mem_reg[rd_ptr_reg];
  assign o_level = count_reg;

endmodule

/* File: hdl/bsw_top.sv */
// address capture, burst counter and write qualification of a burst cache sram
// Summary of operation
// - controller strobe low at edge loads all seventeen address bits.
// - processor strobe low at edge loads all seventeen address bits.
// - any address load also preloads burst counter with two low bits.
// - both strobes low: processor strobe honoured, unless chip select a is high, when the controller strobe acts.
// - processor strobe ignored while chip select a is high.
// - upper address taken only when selected and a strobe is low.
// - lane selects 0..3 govern bytes 0..3 and parity bits 0..3.
// - byte write needs byte write enable low, qualifying the lane selects.
// - advance low at edge steps burst counter in selected order.
// - burst order input high means interleaved, low means linear.
// - burst counter is two bits, wraps within four locations.
// - chip selects sampled on clock; output enable acts without clock.
// - writes captured at the edge and finished internally, no pulse needed.
// - global write low writes all lanes, overriding byte writes.
// - selected only when a low, b high, c low at the edge.
// - data driven only with output enable low and no write cycle.
// - snooze high ignores all other inputs and holds contents.
`timescale 1ns/1ns
module bsw_top (
  input wire logic i_clk_sys, // system clock, 50 MHz
  input wire logic i_reset, // synchronous reset, active high
  input wire logic [bsw_pkg::ADDR_W-1:0] i_addr, // address inputs
  input wire logic i_ctrl_addr_strobe_n, // controller address strobe
  input wire logic i_proc_addr_strobe_n, // processor address strobe
  input wire logic i_burst_advance_n, // burst advance
  input wire logic i_byte_write_enable_n, // byte write enable
  input wire logic [bsw_pkg::LANES-1:0] i_byte_lane_select_n, // byte lane selects
  input wire logic i_global_write_n, // global write
  input wire logic i_chip_sel_a_n, // chip select a
  input wire logic i_chip_sel_b, // chip select b
  input wire logic i_chip_sel_c_n, // chip select c
  input wire logic i_output_enable_n, // asynchronous output enable
  input wire logic i_snooze, // low power standby
  input wire logic i_burst_order, // high interleaved, low linear
  input wire logic [bsw_pkg::DATA_W-1:0] i_dq, // data pins, input side
  output logic [bsw_pkg::DATA_W-1:0] o_dq, // data pins, output side
  output logic o_dq_oe_n, // data pin drive, low drives
  input wire logic [bsw_pkg::LANES-1:0] i_parity_io, // parity pins, input side
  output logic [bsw_pkg::LANES-1:0] o_parity_io, // parity pins, output side
  output logic o_parity_io_oe_n, // parity pin drive, low drives
  output logic [bsw_pkg::ADDR_W-1:0] o_rd_addr, // array read address
  output logic o_rd_valid, // read address is live
  input wire logic [bsw_pkg::DATA_W-1:0] i_rd_data, // array read data
  input wire logic [bsw_pkg::LANES-1:0] i_rd_parity, // array read parity
  output logic o_wr_valid, // write command offered to the array
  input wire logic i_wr_ready, // array takes the write command
  output logic [bsw_pkg::ADDR_W-1:0] o_wr_addr, // write address
  output logic [bsw_pkg::LANES-1:0] o_wr_lanes, // lanes to write
  output logic [bsw_pkg::DATA_W-1:0] o_wr_data, // write data
  output logic [bsw_pkg::LANES-1:0] o_wr_parity, // write parity
  output logic o_wr_accept, // write queue has room
  output logic o_wr_dropped, // a write was lost to a full queue
  output logic o_selected, // device selected
  output logic o_standby, // in snooze standby
  output logic [bsw_pkg::BURST_W-1:0] o_burst_index // current burst offset
);

  ////////////////////////////////////////////////////////////////////////////
  // sampled controls

  bsw_pkg::bsw_chip_sel_type cs;
  logic selected;
  logic proc_go;
  logic ctrl_go;
  logic load;
  logic advance;
  logic byte_wr;
  logic global_wr;
  logic [bsw_pkg::LANES-1:0] lane_mask;

  assign cs = '{sel_a_n: i_chip_sel_a_n, sel_b: i_chip_sel_b, sel_c_n: i_chip_sel_c_n};

  assign selected = !cs.sel_a_n && cs.sel_b && !cs.sel_c_n;

  assign proc_go = !i_snooze && !i_proc_addr_strobe_n && !cs.sel_a_n;
  assign ctrl_go = !i_snooze && !i_ctrl_addr_strobe_n && !proc_go;
  assign load = (proc_go || ctrl_go) && selected;
  assign advance = !i_snooze && !i_burst_advance_n && !load;

  assign global_wr = !i_global_write_n;
  assign byte_wr = !i_byte_write_enable_n;

  genvar l;
  generate
    for (l = 0; l < bsw_pkg::LANES; l++) begin : g_lane
      assign lane_mask[l] = global_wr || (byte_wr && !i_byte_lane_select_n[l]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // address register and burst counter

  bsw_pkg::bsw_state_type state_reg, state_next;
  logic [bsw_pkg::ADDR_W-1:0] addr_reg, addr_next;
  logic [bsw_pkg::BURST_W-1:0] start_reg, start_next;
  logic [bsw_pkg::BURST_W-1:0] step_reg, step_next;
  logic [bsw_pkg::BURST_W-1:0] burst_low;
  logic [bsw_pkg::ADDR_W-1:0] cur_addr;

  assign burst_low = i_burst_order ? (start_reg ^ step_reg) : (start_reg + step_reg);
  assign cur_addr = {addr_reg[bsw_pkg::ADDR_W-1:bsw_pkg::ADDR_UPPER_POS], burst_low};

  always_comb begin
    state_next = state_reg;
    addr_next = addr_reg;
    start_next = start_reg;
    step_next = step_reg;
    case (state_reg)
      bsw_pkg::BSW_STANDBY: begin
        if (!i_snooze) begin
          state_next = bsw_pkg::BSW_IDLE;
        end
      end
      default: begin
        if (i_snooze) begin
          state_next = bsw_pkg::BSW_STANDBY;
        end else if (load) begin
          addr_next = i_addr;
          start_next = i_addr[bsw_pkg::ADDR_LSB_POS +: bsw_pkg::BURST_W];
          step_next = bsw_pkg::BURST_RESET;
          state_next = bsw_pkg::BSW_ACTIVE;
        end else if (proc_go || ctrl_go) begin
          // strobe seen while not selected ends the access
          state_next = bsw_pkg::BSW_IDLE;
        end else if (advance) begin
          step_next = step_reg + bsw_pkg::BURST_STEP_ONE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state_reg <= bsw_pkg::BSW_IDLE;
      addr_reg <= bsw_pkg::ADDR_RESET;
      start_reg <= bsw_pkg::BURST_RESET;
      step_reg <= bsw_pkg::BURST_RESET;
    end else begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      start_reg <= start_next;
      step_reg <= step_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write capture into the queue

  bsw_pkg::bsw_wr_cmd_type wr_cmd;
  bsw_pkg::bsw_wr_cmd_type q_out;
  logic wr_hit;
  logic q_in_ready;
  logic q_out_valid;
  logic q_out_ready;

  assign wr_hit = (state_reg == bsw_pkg::BSW_ACTIVE) && !i_snooze && !load && (lane_mask != bsw_pkg::LANES_NONE);
  assign wr_cmd = '{addr: cur_addr, lanes: lane_mask, parity: i_parity_io, data: i_dq};

  bsw_fifo #(
    .WIDTH(bsw_pkg::WR_CMD_W),
    .DEPTH(bsw_pkg::FIFO_DEPTH)
  ) u_wr_fifo (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_in_valid(wr_hit),
    .o_in_ready(q_in_ready),
    .i_in_data(wr_cmd),
    .o_out_valid(q_out_valid),
    .i_out_ready(q_out_ready),
    .o_out_data(q_out),
    .o_level()
  );

  ////////////////////////////////////////////////////////////////////////////
  // array side output stage and status

  logic wr_valid_reg, wr_valid_next;
  bsw_pkg::bsw_wr_cmd_type wr_out_reg, wr_out_next;
  logic dropped_reg, dropped_next;
  logic wr_seen_reg, wr_seen_next;
  logic [bsw_pkg::DATA_W-1:0] dq_reg, dq_next;
  logic [bsw_pkg::LANES-1:0] par_reg, par_next;
  logic [bsw_pkg::ADDR_W-1:0] rd_addr_reg, rd_addr_next;
  logic rd_valid_reg, rd_valid_next;
  logic sel_reg, sel_next;
  logic standby_reg, standby_next;
  logic [bsw_pkg::BURST_W-1:0] index_reg, index_next;

  assign q_out_ready = !wr_valid_reg || i_wr_ready;

  always_comb begin
    wr_valid_next = wr_valid_reg;
    wr_out_next = wr_out_reg;
    if (q_out_ready) begin
      wr_valid_next = q_out_valid;
      wr_out_next = q_out;
    end
    dropped_next = wr_hit && !q_in_ready;
    wr_seen_next = wr_hit;
    dq_next = i_rd_data;
    par_next = i_rd_parity;
    rd_addr_next = (state_next == bsw_pkg::BSW_ACTIVE) ?
      {addr_next[bsw_pkg::ADDR_W-1:bsw_pkg::ADDR_UPPER_POS],
       (i_burst_order ? (start_next ^ step_next) : (start_next + step_next))} : rd_addr_reg;
    rd_valid_next = (state_next == bsw_pkg::BSW_ACTIVE) && !wr_hit;
    sel_next = (state_next == bsw_pkg::BSW_ACTIVE);
    standby_next = (state_next == bsw_pkg::BSW_STANDBY);
    index_next = step_next;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      wr_valid_reg <= 1'b0;
      wr_out_reg <= '0;
      dropped_reg <= 1'b0;
      wr_seen_reg <= 1'b0;
      dq_reg <= bsw_pkg::DATA_RESET;
      par_reg <= bsw_pkg::PARITY_RESET;
      rd_addr_reg <= bsw_pkg::ADDR_RESET;
      rd_valid_reg <= 1'b0;
      sel_reg <= 1'b0;
      standby_reg <= 1'b0;
      index_reg <= bsw_pkg::BURST_RESET;
    end else begin
      wr_valid_reg <= wr_valid_next;
      wr_out_reg <= wr_out_next;
      dropped_reg <= dropped_next;
      wr_seen_reg <= wr_seen_next;
      dq_reg <= dq_next;
      par_reg <= par_next;
      rd_addr_reg <= rd_addr_next;
      rd_valid_reg <= rd_valid_next;
      sel_reg <= sel_next;
      standby_reg <= standby_next;
      index_reg <= index_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign o_wr_valid = wr_valid_reg;
  assign o_wr_addr = wr_out_reg.addr;
  assign o_wr_lanes = wr_out_reg.lanes;
  assign o_wr_data = wr_out_reg.data;
  assign o_wr_parity = wr_out_reg.parity;
  assign o_wr_accept = q_in_ready;
  assign o_wr_dropped = dropped_reg;
  assign o_dq = dq_reg;
  assign o_parity_io = par_reg;
  assign o_rd_addr = rd_addr_reg;
  assign o_rd_valid = rd_valid_reg;
  assign o_selected = sel_reg;
  assign o_standby = standby_reg;
  assign o_burst_index = index_reg;

  assign o_dq_oe_n = i_output_enable_n || wr_seen_reg || standby_reg;
  assign o_parity_io_oe_n = i_output_enable_n || wr_seen_reg || standby_reg;

endmodule

/* File: test/bsw_array_model.sv */
// array side model: read data pattern and write acceptance
`timescale 1ns/1ns
module bsw_array_model (
  input wire logic i_clk_sys, // clock
  input wire logic [bsw_pkg::ADDR_W-1:0] i_rd_addr, // read address
  input wire logic i_rd_valid, // read address live
  input wire logic i_wr_valid, // write offered
  input wire logic i_stall, // hold off writes
  output logic [bsw_pkg::DATA_W-1:0] o_rd_data, // read word
  output logic [bsw_pkg::LANES-1:0] o_rd_parity, // read parity
  output logic o_wr_ready, // write taken
  output int o_taken // writes taken
);
  logic [bsw_pkg::DATA_W-1:0] word;
  assign word = {15'h0000, i_rd_addr};
  // idle read lines show the inverse pattern
  assign o_rd_data = i_rd_valid ? word : ~word;
  assign o_rd_parity = i_rd_valid ? i_rd_addr[3:0] : ~i_rd_addr[3:0];
  assign o_wr_ready = !i_stall;
  int taken_cnt = 0;
  assign o_taken = taken_cnt;
  always @(posedge i_clk_sys) if (i_wr_valid && o_wr_ready) taken_cnt <= taken_cnt + 1;
endmodule

/* File: test/bsw_top_chk.sv */
// assertions on the ports of the burst sram control
`timescale 1ns/1ns
module bsw_top_chk (
  input wire logic i_clk_sys, // clock
  input wire logic i_reset, // reset
  input wire logic [bsw_pkg::ADDR_W-1:0] i_addr, // address
  input wire logic i_ctrl_addr_strobe_n, // strobe
  input wire logic i_proc_addr_strobe_n, // strobe
  input wire logic i_burst_advance_n, // advance
  input wire logic i_byte_write_enable_n, // byte write
  input wire logic [bsw_pkg::LANES-1:0] i_byte_lane_select_n, // lanes
  input wire logic i_global_write_n, // global write
  input wire logic i_chip_sel_a_n, // select
  input wire logic i_chip_sel_b, // select
  input wire logic i_chip_sel_c_n, // select
  input wire logic i_output_enable_n, // output enable
  input wire logic i_snooze, // standby
  input wire logic i_burst_order, // order
  input wire logic o_dq_oe_n, // data drive
  input wire logic o_parity_io_oe_n, // parity drive
  input wire logic [bsw_pkg::ADDR_W-1:0] o_rd_addr, // read address
  input wire logic o_wr_valid, // command
  input wire logic i_wr_ready, // command taken
  input wire logic [bsw_pkg::ADDR_W-1:0] o_wr_addr, // command address
  input wire logic [bsw_pkg::LANES-1:0] o_wr_lanes, // command lanes
  input wire logic [bsw_pkg::DATA_W-1:0] o_wr_data, // command data
  input wire logic o_selected, // selected
  input wire logic o_standby, // standby
  input wire logic [bsw_pkg::BURST_W-1:0] o_burst_index // step count
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  logic go, sel, load, step, wr;
  logic [1:0] start_reg;
  logic [1:0] start_next;
  assign go = !i_snooze && !o_standby;
  assign sel = !i_chip_sel_a_n && i_chip_sel_b && !i_chip_sel_c_n;
  assign load = go && sel && (!i_proc_addr_strobe_n || !i_ctrl_addr_strobe_n);
  assign step = go && i_proc_addr_strobe_n && i_ctrl_addr_strobe_n && !i_burst_advance_n;
  assign wr = go && o_selected && i_proc_addr_strobe_n && i_ctrl_addr_strobe_n
    && (!i_global_write_n || (!i_byte_write_enable_n && i_byte_lane_select_n != 4'hf));
  // burst start held for the order check
  always_comb start_next = load ? i_addr[1:0] : start_reg;
  always_ff @(posedge i_clk_sys) start_reg <= start_next;
  sequence s_load; load; endsequence
  sequence s_step; step; endsequence
  a_load_addr: assert property (s_load |=> o_rd_addr == $past(i_addr) && o_selected)
    else $error("address not captured");
  a_load_preload: assert property (s_load |=> o_burst_index == 2'h0)
    else $error("burst counter not preloaded");
  a_sel_cause: assert property ($rose(o_selected) |-> $past(load))
    else $error("selected without a valid load");
  a_desel_refused: assert property (go && !sel && (!i_ctrl_addr_strobe_n
    || (!i_proc_addr_strobe_n && !i_chip_sel_a_n)) |=> !o_selected) else $error("strobe taken while deselected");
  a_proc_gated: assert property (go && i_chip_sel_a_n && !i_proc_addr_strobe_n && i_ctrl_addr_strobe_n
    && i_burst_advance_n |=> $stable(o_selected) && $stable(o_burst_index)) else $error("gated strobe acted");
  a_step_count: assert property (s_step |=> o_burst_index == 2'($past(o_burst_index) + 2'h1))
    else $error("burst counter did not step");
  a_order_addr: assert property (s_step ##0 o_selected |=> o_rd_addr[1:0] == ($past(i_burst_order) ?
    (start_reg ^ o_burst_index) : 2'(start_reg + o_burst_index))) else $error("burst order wrong");
  a_hold_counter: assert property (go && i_proc_addr_strobe_n && i_ctrl_addr_strobe_n && i_burst_advance_n
    |=> $stable(o_burst_index)) else $error("burst counter moved");
  a_oe_async: assert property (i_output_enable_n || o_standby |-> o_dq_oe_n && o_parity_io_oe_n)
    else $error("pins driven with output enable off");
  a_write_float: assert property (wr |=> o_dq_oe_n)
    else $error("pins driven in a write cycle");
  a_snooze_in: assert property (i_snooze [*2] |=> o_standby)
    else $error("standby not entered");
  a_cmd_held: assert property (o_wr_valid && !i_wr_ready |=> o_wr_valid && $stable(o_wr_addr)
    && $stable(o_wr_lanes) && $stable(o_wr_data)) else $error("write command not held");
endmodule
bind bsw_top bsw_top_chk bsw_top_chk_inst (.i_clk_sys, .i_reset, .i_addr, .i_ctrl_addr_strobe_n,
  .i_proc_addr_strobe_n, .i_burst_advance_n, .i_byte_write_enable_n, .i_byte_lane_select_n,
  .i_global_write_n, .i_chip_sel_a_n, .i_chip_sel_b, .i_chip_sel_c_n, .i_output_enable_n, .i_snooze,
  .i_burst_order, .o_dq_oe_n, .o_parity_io_oe_n, .o_rd_addr, .o_wr_valid, .i_wr_ready, .o_wr_addr,
  .o_wr_lanes, .o_wr_data, .o_selected, .o_standby, .o_burst_index);

/* File: test/tb_bsw_top.sv */
// self-checking bench for the burst sram control
`timescale 1ns/1ns
module tb_bsw_top;
  logic clk = 1'b0, rst = 1'b1, ctrl_n = 1'b1, proc_n = 1'b1, adv_n = 1'b1, bwe_n = 1'b1, gw_n = 1'b1;
  logic sa_n = 1'b0, sb = 1'b1, sc_n = 1'b0, oe_n = 1'b0, snz = 1'b0, order = 1'b0, stall = 1'b0;
  logic [16:0] addr = 17'h00000;
  logic [3:0] lane_n = 4'hf, par = 4'h0;
  logic [31:0] dq = 32'h00000000;
  logic [31:0] dq_out, rd_data, wr_data, d;
  logic [3:0] par_out, rd_par, wr_lanes, wr_par;
  logic [16:0] rd_addr, wr_addr;
  logic [1:0] bidx, lo;
  logic dq_oe_n, par_oe_n, rd_valid, wr_valid, wr_ready, wr_accept, wr_dropped, selected, standby;
  logic [16:0] base = 17'h1abcd;
  logic [2:0] sel_bad [3] = '{3'b110, 3'b000, 3'b011};
  logic [9:0] wt [4] = '{10'b0111111111, 10'b0001011111, 10'b1010100101, 10'b1100000000};
  int num_errors = 0, compares = 0, n, t0, taken;
  bit seen;
  always #10 clk = ~clk;
  bsw_top bsw_top_inst (.i_clk_sys(clk), .i_reset(rst), .i_addr(addr), .i_ctrl_addr_strobe_n(ctrl_n),
    .i_proc_addr_strobe_n(proc_n), .i_burst_advance_n(adv_n), .i_byte_write_enable_n(bwe_n),
    .i_byte_lane_select_n(lane_n), .i_global_write_n(gw_n), .i_chip_sel_a_n(sa_n), .i_chip_sel_b(sb),
    .i_chip_sel_c_n(sc_n), .i_output_enable_n(oe_n), .i_snooze(snz), .i_burst_order(order), .i_dq(dq),
    .o_dq(dq_out), .o_dq_oe_n(dq_oe_n), .i_parity_io(par), .o_parity_io(par_out), .o_parity_io_oe_n(par_oe_n),
    .o_rd_addr(rd_addr), .o_rd_valid(rd_valid), .i_rd_data(rd_data), .i_rd_parity(rd_par),
    .o_wr_valid(wr_valid), .i_wr_ready(wr_ready), .o_wr_addr(wr_addr), .o_wr_lanes(wr_lanes),
    .o_wr_data(wr_data), .o_wr_parity(wr_par), .o_wr_accept(wr_accept), .o_wr_dropped(wr_dropped),
    .o_selected(selected), .o_standby(standby), .o_burst_index(bidx));
  bsw_array_model bsw_array_model_inst (.i_clk_sys(clk), .i_rd_addr(rd_addr), .i_rd_valid(rd_valid),
    .i_wr_valid(wr_valid), .i_stall(stall), .o_rd_data(rd_data), .o_rd_parity(rd_par),
    .o_wr_ready(wr_ready), .o_taken(taken));
  ////////////////////////////////////////
  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [31:0] lane_mask(input logic [3:0] l);
    lane_mask = {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
  endfunction
  task automatic load(input logic [16:0] a, input logic by_proc);
    @(posedge clk);
    addr <= a;
    if (by_proc) proc_n <= 1'b0;
    else ctrl_n <= 1'b0;
    @(posedge clk);
    proc_n <= 1'b1;
    ctrl_n <= 1'b1;
    #1;
  endtask
  task automatic write(input logic g, input logic b, input logic [3:0] l, input logic [31:0] v);
    @(posedge clk);
    gw_n <= g;
    bwe_n <= b;
    lane_n <= l;
    dq <= v;
    par <= v[3:0];
    @(posedge clk);
    gw_n <= 1'b1;
    bwe_n <= 1'b1;
    lane_n <= 4'hf;
    #1;
  endtask
  task automatic wait_cmd(output bit got);
    got = 0;
    repeat (8) begin
      @(posedge clk);
      #1;
      if (wr_valid === 1'b1) begin
        got = 1;
        break;
      end
    end
  endtask
  ////////////////////////////////////////
  initial begin
    #100000;
    num_errors++;
    close_out();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk_val("selected at reset", 1'b0, selected);
    repeat (2) @(posedge clk);
    #1;
    chk_val("accept after reset", 1'b1, wr_accept);
    for (int m = 0; m < 2; m++) begin
      @(posedge clk);
      order <= m[0];
      load(base, m[0]);
      chk_val("load addr", base, rd_addr);
      chk_val("start index", 2'h0, bidx);
      @(posedge clk);
      adv_n <= 1'b0;
      for (int k = 1; k < 5; k++) begin
        @(posedge clk);
        if (k == 4) adv_n <= 1'b1;
        #1;
        lo = m[0] ? (2'h1 ^ k[1:0]) : 2'(2'h1 + k[1:0]);
        chk_val("burst addr", {base[16:2], lo}, rd_addr);
        chk_val("burst index", k[1:0], bidx);
      end
      @(posedge clk);
      #1;
      chk_val("held index", 2'h0, bidx);
      chk_val("read word", {15'h0000, base}, dq_out);
      chk_val("read parity", base[3:0], par_out);
      chk_val("read valid", 1'b1, rd_valid);
      chk_val("pins driven", 1'b0, dq_oe_n);
      $display("burst test done, order %0d", m);
    end
    for (int s = 0; s < 3; s++) begin
      @(posedge clk);
      {sa_n, sb, sc_n} <= sel_bad[s];
      load(17'h00004, s != 1);
      chk_val("deselected", s == 0, selected);
      chk_val("addr kept", base, rd_addr);
    end
    @(posedge clk);
    {sa_n, sb, sc_n} <= 3'b010;
    load(17'h00a40, 1'b0);
    chk_val("reselected", 1'b1, selected);
    $display("select test done");
    for (int w = 0; w < 4; w++) begin
      d = 32'h11223344 + 32'(w) * 32'h01010101;
      write(wt[w][9], wt[w][8], wt[w][7:4], d);
      chk_val("write float", wt[w][3:0] != 4'h0, dq_oe_n);
      chk_val("read paused", wt[w][3:0] == 4'h0, rd_valid);
      wait_cmd(seen);
      chk_val("command seen", wt[w][3:0] != 4'h0, seen);
      if (seen) begin
        chk_val("lanes", wt[w][3:0], wr_lanes);
        chk_val("write addr", 17'h00a40, wr_addr);
        chk_val("write data", d & lane_mask(wt[w][3:0]), wr_data & lane_mask(wt[w][3:0]));
        chk_val("write parity", d[3:0] & wt[w][3:0], wr_par & wt[w][3:0]);
      end
    end
    $display("write test done");
    @(posedge clk);
    stall <= 1'b1;
    gw_n <= 1'b0;
    t0 = taken;
    n = 0;
    #1;
    while (wr_accept === 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk_val("fill count", 1'b1, n >= bsw_pkg::FIFO_DEPTH && n < 40);
    @(posedge clk);
    gw_n <= 1'b1;
    #1;
    chk_val("write dropped", 1'b1, wr_dropped);
    @(posedge clk);
    stall <= 1'b0;
    repeat (45) @(posedge clk);
    #1;
    chk_val("drained count", n, taken - t0);
    chk_val("queue empty", 1'b0, wr_valid);
    chk_val("queue room", 1'b1, wr_accept);
    $display("buffer test done");
    @(posedge clk);
    oe_n <= 1'b1;
    #1;
    chk_val("async float", 2'h3, {dq_oe_n, par_oe_n});
    @(posedge clk);
    oe_n <= 1'b0;
    #1;
    chk_val("async drive", 2'h0, {dq_oe_n, par_oe_n});
    @(posedge clk);
    snz <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk_val("standby", 2'h3, {standby, dq_oe_n});
    @(posedge clk);
    snz <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk_val("awake", 1'b0, standby);
    load(17'h0f0f2, 1'b1);
    chk_val("load after standby", 17'h0f0f2, rd_addr);
    $display("output enable and standby test done");
    close_out();
  end
endmodule
